// >>> pkg/rct_pkg.sv
`default_nettype none
package rct_pkg;

  // =====================================================================
  // Register offsets
  localparam logic [7:0] MAIN_TIMER_CONTROL_OFS     = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_OFS             = 8'h01;
  localparam logic [7:0] IRQ_FLAG_OFS               = 8'h02;
  localparam logic [7:0] RELOAD_VALUE_LOW_BYTE_OFS  = 8'h18;
  localparam logic [7:0] RELOAD_VALUE_HIGH_BYTE_OFS = 8'h19;

  // =====================================================================
  // Field positions
  localparam int COUNTDOWN_RUN_ENABLE_BIT = 1;
  localparam int AUTO_RELOAD_ENABLE_BIT   = 2;
  localparam int TICK_RATE_SELECT_LO_BIT  = 5;
  localparam int TICK_RATE_SELECT_HI_BIT  = 6;
  localparam int EXPIRY_IRQ_ENABLE_BIT    = 1;
  localparam int EXPIRY_FLAG_BIT          = 1;

  // Bits of the control register guarded while the timer runs
  localparam logic [7:0] RUN_LOCKED_MASK = 8'h64;
  // Enable register holds bits 4..0 only
  localparam logic [7:0] IRQ_ENABLE_MASK = 8'h1F;

  // =====================================================================
  // Reset values
  localparam logic [7:0]  MAIN_TIMER_CONTROL_RST = 8'h99;
  localparam logic [7:0]  IRQ_ENABLE_RST         = 8'h00;
  localparam logic [15:0] RELOAD_VALUE_RST       = 16'h0000;

  // =====================================================================
  // Oscillator edges per countdown tick: 32 Hz, 8 Hz, 1 Hz, 0.5 Hz
  localparam int OSC_HZ          = 32768;
  localparam int TICK_32HZ_DIV   = OSC_HZ / 32;
  localparam int TICK_8HZ_DIV    = OSC_HZ / 8;
  localparam int TICK_1HZ_DIV    = OSC_HZ;
  localparam int TICK_HALF_HZ_DIV = OSC_HZ * 2;
  localparam int PRESCALE_W      = 16;

  typedef enum logic [1:0] {
    RCT_RATE_32HZ   = 2'h0,
    RCT_RATE_8HZ    = 2'h1,
    RCT_RATE_1HZ    = 2'h2,
    RCT_RATE_HALFHZ = 2'h3
  } rct_rate_t;

endpackage
`default_nettype wire

// >>> rtl/rct_countdown_timer.sv
// Contract
// - Timer counts only while run-enable set
// - Rate field picks 32/8/1/0.5 Hz tick
// - Reload value from bytes at 18h, 19h
// - Reload 1..65535, one decrement per tick
// - Reload value zero stops counting
// - Period ends when counter reaches zero
// - Auto-reload restarts period after each expiry
// - Reload costs one tick: later periods n+1
// - Expiry sets flag when irq enable set
// - Interrupt mirrors flag; writing zero releases
// - Rate and auto-reload writable only when stopped
// - Reload bytes writable only if stopped, no auto-reload
// - Open-drain active-low irq; flag sticky until cleared
`timescale 1ns/10ps
`default_nettype none
module rct_countdown_timer
#(
  parameter int PRESCALE_W = rct_pkg::PRESCALE_W
)
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_osc_32k,
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  output logic            o_irq_n_out,
  output logic            o_irq_n_oe
);

  // =====================================================================
  // Oscillator synchroniser and prescaler
  logic                               osc_meta;
  logic                               osc_sync;
  logic                               osc_prev;
  logic [PRESCALE_W-1:0]              prescale;
  logic [PRESCALE_W-1:0]              next_prescale;
  logic [PRESCALE_W-1:0]              div_mask;
  logic                               osc_edge;
  logic                               tick;

  // =====================================================================
  // Registers and counter
  logic [7:0]  ctrl;
  logic [7:0]  next_ctrl;
  logic [7:0]  irq_en;
  logic [7:0]  next_irq_en;
  logic [15:0] reload;
  logic [15:0] next_reload;
  logic [15:0] count;
  logic [15:0] next_count;
  logic        reload_due;
  logic        next_reload_due;
  logic        run_prev;
  logic        expiry_flag;
  logic        next_expiry_flag;
  logic        expiry;
  logic [7:0]  next_rdata;
  logic        run;
  logic        auto_reload;
  rct_pkg::rct_rate_t rate;

  assign run         = ctrl[rct_pkg::COUNTDOWN_RUN_ENABLE_BIT];
  assign auto_reload = ctrl[rct_pkg::AUTO_RELOAD_ENABLE_BIT];
  assign rate        = rct_pkg::rct_rate_t'({ctrl[rct_pkg::TICK_RATE_SELECT_HI_BIT],
                                             ctrl[rct_pkg::TICK_RATE_SELECT_LO_BIT]});

  // =====================================================================
  // Elaboration checks
  // Slowest tick needs every divider bit; a narrower prescaler would alias rates
  if (PRESCALE_W < $clog2(rct_pkg::TICK_HALF_HZ_DIV))
  begin : g_prescale_check
    $error("Prescaler too narrow for the slowest tick");
  end

  // =====================================================================
  // Tick generation
  always_comb
  begin
    osc_edge = osc_sync & ~osc_prev;
    unique case (rate)
      rct_pkg::RCT_RATE_32HZ:  div_mask = PRESCALE_W'(rct_pkg::TICK_32HZ_DIV - 1);
      rct_pkg::RCT_RATE_8HZ:   div_mask = PRESCALE_W'(rct_pkg::TICK_8HZ_DIV - 1);
      rct_pkg::RCT_RATE_1HZ:   div_mask = PRESCALE_W'(rct_pkg::TICK_1HZ_DIV - 1);
      rct_pkg::RCT_RATE_HALFHZ: div_mask = PRESCALE_W'(rct_pkg::TICK_HALF_HZ_DIV - 1);
    endcase
    // Free-running divider; a tick is one ref-clock pulse on an oscillator edge
    next_prescale = osc_edge ? prescale + PRESCALE_W'(16'h0001) : prescale;
    tick          = osc_edge && ((prescale & div_mask) == div_mask);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
      prescale <= '0;
    end
    else
    begin
      osc_meta <= i_osc_32k;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
      prescale <= next_prescale;
    end
  end

  // =====================================================================
  // Register writes, countdown and flag
  always_comb
  begin
    next_ctrl        = ctrl;
    next_irq_en      = irq_en;
    next_reload      = reload;
    next_count       = count;
    next_reload_due  = reload_due;
    next_expiry_flag = expiry_flag;
    expiry           = 1'b0;

    if (i_reg_wr)
    begin
      unique case (i_reg_addr)
        rct_pkg::MAIN_TIMER_CONTROL_OFS:
          // Rate and auto-reload keep their value while running
          if (run)
            next_ctrl = (ctrl & rct_pkg::RUN_LOCKED_MASK)
                      | (i_reg_wdata & ~rct_pkg::RUN_LOCKED_MASK);
          else
            next_ctrl = i_reg_wdata;
        rct_pkg::IRQ_ENABLE_OFS:
          next_irq_en = i_reg_wdata & rct_pkg::IRQ_ENABLE_MASK;
        rct_pkg::IRQ_FLAG_OFS:
          if (!i_reg_wdata[rct_pkg::EXPIRY_FLAG_BIT])
            next_expiry_flag = 1'b0;
        rct_pkg::RELOAD_VALUE_LOW_BYTE_OFS:
          if (!run && !auto_reload)
            next_reload[7:0] = i_reg_wdata;
        rct_pkg::RELOAD_VALUE_HIGH_BYTE_OFS:
          if (!run && !auto_reload)
            next_reload[15:8] = i_reg_wdata;
        default:
          next_ctrl = ctrl;
      endcase
    end

    if (run && !run_prev)
    begin
      // Start always loads a fresh period, without the reload tick
      next_count      = reload;
      next_reload_due = 1'b0;
    end
    else if (run && tick && (reload != 16'h0000))
    begin
      // Reload eats a whole tick, so later periods last n+1
      if (reload_due)
      begin
        next_count      = reload;
        next_reload_due = 1'b0;
      end
      else if (count != 16'h0000)
      begin
        next_count = count - 16'h0001;
        if (count == 16'h0001)
        begin
          expiry          = 1'b1;
          next_reload_due = auto_reload;
        end
      end
    end

    // A new expiry beats a clear in the same cycle
    if (expiry && irq_en[rct_pkg::EXPIRY_IRQ_ENABLE_BIT])
      next_expiry_flag = 1'b1;

    unique case (i_reg_addr)
      rct_pkg::MAIN_TIMER_CONTROL_OFS:     next_rdata = next_ctrl;
      rct_pkg::IRQ_ENABLE_OFS:             next_rdata = next_irq_en;
      rct_pkg::IRQ_FLAG_OFS:               next_rdata = {6'h00, next_expiry_flag, 1'b0};
      rct_pkg::RELOAD_VALUE_LOW_BYTE_OFS:  next_rdata = next_reload[7:0];
      rct_pkg::RELOAD_VALUE_HIGH_BYTE_OFS: next_rdata = next_reload[15:8];
      default:                             next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      ctrl        <= rct_pkg::MAIN_TIMER_CONTROL_RST;
      irq_en      <= rct_pkg::IRQ_ENABLE_RST;
      reload      <= rct_pkg::RELOAD_VALUE_RST;
      count       <= '0;
      reload_due  <= 1'b0;
      run_prev    <= 1'b0;
      expiry_flag <= 1'b0;
      o_reg_rdata <= 8'h00;
      o_irq_n_out <= 1'b0;
      o_irq_n_oe  <= 1'b0;
    end
    else
    begin
      ctrl        <= next_ctrl;
      irq_en      <= next_irq_en;
      reload      <= next_reload;
      count       <= next_count;
      reload_due  <= next_reload_due;
      run_prev    <= run;
      expiry_flag <= next_expiry_flag;
      o_reg_rdata <= next_rdata;
      // Open drain: only ever pulls low
      o_irq_n_out <= 1'b0;
      o_irq_n_oe  <= next_expiry_flag;
    end
  end

endmodule // rct_countdown_timer
`default_nettype wire

// >>> tb/rct_countdown_timer_sva.sv
`timescale 1ns/10ps
`default_nettype none
module rct_countdown_timer_sva
(
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  input wire logic       i_osc_32k,
  input wire logic       i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_irq_n_out,
  input wire logic       o_irq_n_oe
);
  // ==========================================
  // Register port and interrupt pin
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic clr_now;
  logic clr_q;
  assign clr_now = i_reg_wr && i_reg_addr == 8'h02 && !i_reg_wdata[1];
  always_ff @(posedge i_ref_clk) clr_q <= clr_now;
  // Read data shows the control value once the address has stood a cycle
  sequence ctl_view;
    i_reg_addr == 8'h00 ##1 i_reg_addr == 8'h00;
  endsequence
  out_low_a: assert property (o_irq_n_out == 1'b0) else $error("pin drive not low");
  irq_sticky_a: assert property (o_irq_n_oe && !clr_now |=> o_irq_n_oe) else $error("flag lost");
  irq_release_a: assert property ($fell(o_irq_n_oe) |-> clr_q) else $error("flag fell alone");
  unmapped_zero_a: assert property (!(i_reg_addr inside {8'h00, 8'h01, 8'h02, 8'h18, 8'h19})
    |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  ctl_write_a: assert property (i_reg_wr && i_reg_addr == 8'h00
    |=> (o_reg_rdata & 8'h9B) == ($past(i_reg_wdata) & 8'h9B)) else $error("control write lost");
  ctl_lock_a: assert property (ctl_view ##0 (i_reg_wr && o_reg_rdata[1])
    |=> (o_reg_rdata & 8'h64) == ($past(o_reg_rdata) & 8'h64)) else $error("locked bits moved");
  flag_mirror_a: assert property (i_reg_addr == 8'h02
    |=> o_reg_rdata == {6'h00, o_irq_n_oe, 1'b0}) else $error("pin and flag differ");
  ie_write_a: assert property (i_reg_wr && i_reg_addr == 8'h01
    |=> o_reg_rdata == ($past(i_reg_wdata) & 8'h1F)) else $error("enable write lost");
endmodule // rct_countdown_timer_sva
bind rct_countdown_timer rct_countdown_timer_sva u_sva
(
  .i_ref_clk   (i_ref_clk),
  .i_rst       (i_rst),
  .i_osc_32k   (i_osc_32k),
  .i_reg_wr    (i_reg_wr),
  .i_reg_addr  (i_reg_addr),
  .i_reg_wdata (i_reg_wdata),
  .o_reg_rdata (o_reg_rdata),
  .o_irq_n_out (o_irq_n_out),
  .o_irq_n_oe  (o_irq_n_oe)
);
`default_nettype wire

// >>> tb/rct_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module rct_host_model
(
  input  wire logic       i_clk,
  output logic            o_wr,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  // ==========================================
  // Host register cycles
  initial
  begin
    o_wr = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // Data is inverted once released so stale bytes never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    o_addr <= a;
    @(posedge i_clk);
  endtask
endmodule // rct_host_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic       clk, rst, osc_on, wr, drv, oe;
  logic       osc = 1'b0;
  logic [7:0] addr, wdata, rdata;
  int         fails, checks, ctl, ie, fl, rl, t0, t1, oscn;
  int         cyc = 0;
  logic [7:0] at [6] = '{8'h00, 8'h01, 8'h02, 8'h18, 8'h19, 8'h07};
  wire        irq_pin = oe ? drv : 1'b1;
  rct_countdown_timer uut (.i_ref_clk(clk), .i_rst(rst), .i_osc_32k(osc), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_irq_n_out(drv), .o_irq_n_oe(oe));
  rct_host_model host (.i_clk(clk), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
  // ==========================================
  // Clock, oscillator at 4 cycles, hang limit
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (osc_on && cyc[0])
    begin
      osc <= ~osc;
      if (!osc) oscn <= oscn + 1;
    end
    if (cyc == 90000)
    begin
      fails++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED %s exp %0h seen %0h", n, e, s);
    end
  endtask
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    case (a)
      8'h00: ctl = ctl[1] ? (d & 8'h9B) | (ctl & 8'h64) : d;
      8'h01: ie = d & 8'h1F;
      8'h02: if (!d[1]) fl = 0;
      8'h18: if (ctl[2:1] == 0) rl[7:0] = d;
      8'h19: if (ctl[2:1] == 0) rl[15:8] = d;
      default: ;
    endcase
  endtask
  task automatic mrd(input logic [7:0] a);
    int e;
    host.rd(a);
    #1;
    case (a)
      8'h00: e = ctl;
      8'h01: e = ie;
      8'h02: e = fl << 1;
      8'h18: e = rl & 8'hFF;
      8'h19: e = rl >> 8;
      default: e = 0;
    endcase
    chk("rdata", rdata, e[7:0]);
  endtask
  // Tick is 1024 osc edges, 4096 cycles here
  task automatic wirq(input int lim, output int t);
    t = -1;
    for (int i = 0; i < lim && t < 0; i++)
    begin
      @(posedge clk);
      #1;
      if (irq_pin === 1'b0) t = cyc;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    logic [7:0] a;
    rst = 1'b1;
    osc_on = 1'b0;
    ctl = 8'h99;
    void'($urandom(93));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (at[i]) mrd(at[i]);
    for (int r = 0; r < 4; r++)
    begin
      mwr(8'h00, 8'(r << 5));
      mrd(8'h00);
    end
    repeat (40)
    begin
      a = at[$urandom % 6];
      mwr(a, 8'($urandom));
      mrd(a);
    end
    mwr(8'h00, 8'h00);
    mwr(8'h00, 8'h00);
    mwr(8'h18, 8'h02);
    mwr(8'h19, 8'h00);
    mwr(8'h01, 8'h02);
    osc_on <= 1'b1;
    mwr(8'h00, 8'h06);
    t0 = cyc;
    wirq(8300, t1);
    chk("first", t1 > t0 + 4096 && t1 <= t0 + 8210, 1);
    chk("first phase", oscn % 1024, 0);
    fl = 1;
    mrd(8'h02);
    repeat (50) @(posedge clk);
    chk("held", irq_pin, 0);
    mwr(8'h02, 8'h00);
    #1;
    chk("clear", irq_pin, 1);
    wirq(12400, t0);
    chk("period", t0 - t1, 12288);
    mwr(8'h02, 8'h00);
    mrd(8'h00);
    mwr(8'h00, 8'h00);
    wirq(12400, t0);
    chk("stopped", t0, -1);
    mwr(8'h00, 8'h00);
    mwr(8'h00, 8'h02);
    wirq(8300, t0);
    chk("single", t0 >= 0, 1);
    mwr(8'h02, 8'h00);
    wirq(12400, t0);
    chk("no reload", t0, -1);
    mwr(8'h00, 8'h00);
    mwr(8'h18, 8'h01);
    mwr(8'h00, 8'h22);
    wirq(16500, t0);
    chk("slow tick", t0 >= 0, 1);
    chk("slow phase", oscn % 4096, 0);
    mwr(8'h02, 8'h00);
    mwr(8'h00, 8'h00);
    mwr(8'h00, 8'h00);
    mwr(8'h18, 8'h00);
    mwr(8'h00, 8'h02);
    wirq(12400, t0);
    chk("zero", t0, -1);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
